// ==== core/sws_seq_regs.vh ====
`ifndef SWS_SEQ_REGS_VH
`define SWS_SEQ_REGS_VH

// state codes: {svOne, svTwo, svThree}
`define SWS_ST_IDLE     3'h0
`define SWS_ST_RD_WAIT  3'h2
`define SWS_ST_RD_LAST  3'h3
`define SWS_ST_WR_WAIT  3'h4
`define SWS_ST_WR_LAST  3'h5
`define SWS_ST_DONE     3'h6
`define SWS_ST_SPARE    3'h7

// state vector width and bit positions
`define SWS_ST_W        3
`define SWS_SV_ONE_BIT  2
`define SWS_SV_TWO_BIT  1
`define SWS_SV_THR_BIT  0

// processor clock ceiling and wait states per access
`define SWS_PROC_MAX_MHZ    20
`define SWS_WAIT_STATES     1
`define SWS_ACCESS_CLOCKS   3

// output values held during reset
`define SWS_RST_READY       1'h1
`define SWS_RST_STROBE_N    1'h1

`endif

// ==== core/sws_out_decode.v ====
`timescale 1ns/1ps
`default_nettype none
`include "sws_seq_regs.vh"

module sws_out_decode (
    // clock and reset
    input  wire                     clk_sys,
    input  wire                     rstn,
    // state code about to be entered
    input  wire [`SWS_ST_W-1:0]     nxtState,
    // registered outputs
    output reg                      ready_ff,
    output reg                      memOeN_ff,
    output reg                      memWrN_ff,
    output reg                      xcvrEnN_ff,
    output reg                      xcvrDirN_ff
);

    wire svOne;
    wire svTwo;
    reg  nxt_ready;
    reg  nxt_xcvrEnN;
    reg  nxt_xcvrDirN;

    assign svOne = nxtState[`SWS_SV_ONE_BIT];
    assign svTwo = nxtState[`SWS_SV_TWO_BIT];

    // ready low only in the wait state; transceivers follow the access
    always @* begin
        nxt_ready    = 1'b1;
        nxt_xcvrEnN  = 1'b1;
        nxt_xcvrDirN = 1'b1;
        case (nxtState)
            `SWS_ST_RD_WAIT: begin
                nxt_ready    = 1'b0; // R3
                nxt_xcvrEnN  = 1'b0; // R5
                nxt_xcvrDirN = 1'b0; // R5
            end
            `SWS_ST_RD_LAST: begin
                nxt_xcvrEnN  = 1'b0;
                nxt_xcvrDirN = 1'b0;
            end
            `SWS_ST_WR_WAIT: begin
                nxt_ready    = 1'b0; // R3
                nxt_xcvrEnN  = 1'b0; // R5
            end
            `SWS_ST_WR_LAST: begin
                nxt_xcvrEnN  = 1'b0;
            end
            default: begin
                nxt_ready    = 1'b1;
            end
        endcase
    end

    // all outputs change on the rising clock edge only
    always @(posedge clk_sys) begin // R11
        if (!rstn) begin
            ready_ff    <= `SWS_RST_READY;
            memOeN_ff   <= `SWS_RST_STROBE_N;
            memWrN_ff   <= `SWS_RST_STROBE_N;
            xcvrEnN_ff  <= `SWS_RST_STROBE_N;
            xcvrDirN_ff <= `SWS_RST_STROBE_N;
        end else begin
            ready_ff    <= nxt_ready;
            memOeN_ff   <= ~(~svOne & svTwo); // R12
            memWrN_ff   <= ~(svOne & ~svTwo); // R12
            xcvrEnN_ff  <= nxt_xcvrEnN;
            xcvrDirN_ff <= nxt_xcvrDirN;
        end
    end

endmodule // sws_out_decode

`default_nettype wire

// ==== core/sws_sequencer.v ====
// Function
// [R1] Run with the processor clock up to 20 MHz and add exactly one wait state to each normal access.
// [R2] The processor supplies bus status, read, write and held address strobe, and the decoder supplies an active-low select.
// [R3] Drive ready back to the processor and pull it low to stretch the cycle by one wait state.
// [R4] Drive separate active-low output-enable and write strobes to the static RAM.
// [R5] Drive an active-low transceiver enable and an active-low transceiver direction.
// [R6] Hold the behaviour in three state bits and decode every output from them.
// [R7] The address strobe input is an active-low held copy of the latch pulse.
// [R8] That held strobe may be a set-reset latch cleared by the inverted transceiver enable.
// [R9] Each access spans three clock periods from the first bus state to the third.
// [R10] On a read the output enable goes active at the edge opening the second bus state.
// [R11] State and registered outputs change only on rising clock edges.
// [R12] Output enable only where svOne is low and svTwo high; write strobe only the reverse.
// [R13] Stay idle with no strobes while bus status is high, select is off or no held strobe.
`timescale 1ns/1ps
`default_nettype none
`include "sws_seq_regs.vh"

module sws_sequencer (
    // processor phase-two clock and reset
    input  wire                     clk_sys,
    input  wire                     rstn,
    // processor bus controls
    input  wire                     busCycleStatusBit,
    input  wire                     readStrobeN,
    input  wire                     writeStrobeN,
    input  wire                     heldAddressLatchN,
    // address decoder
    input  wire                     sramSelectN,
    // back to the processor
    output wire                     ready,
    // static RAM strobes
    output wire                     memoryOutputEnableN,
    output wire                     memoryWritePulseN,
    // data transceivers
    output wire                     transceiverEnableN,
    output wire                     transceiverDirectionN,
    // state variables {svOne, svTwo, svThree}
    output wire [`SWS_ST_W-1:0]     stateVars
);

    reg  [`SWS_ST_W-1:0] state_ff;
    reg  [`SWS_ST_W-1:0] nxt_state;
    wire                 accessReq;
    wire                 readReq;
    wire                 writeReq;

    // a new access needs select, memory status and the held strobe
    assign accessReq = ~busCycleStatusBit & ~sramSelectN
                     & ~heldAddressLatchN; // R2 R7 R13
    assign readReq   = accessReq & ~readStrobeN;
    assign writeReq  = accessReq & ~readStrobeN ? 1'b0
                     : accessReq & ~writeStrobeN;

    // next state: idle, wait state, last state, release
    always @* begin
        nxt_state = state_ff;
        case (state_ff)
            `SWS_ST_IDLE: begin
                if (readReq) begin
                    nxt_state = `SWS_ST_RD_WAIT; // R10
                end else if (writeReq) begin
                    nxt_state = `SWS_ST_WR_WAIT;
                end else begin
                    nxt_state = `SWS_ST_IDLE; // R13
                end
            end
            `SWS_ST_RD_WAIT: begin
                nxt_state = `SWS_ST_RD_LAST; // R1
            end
            `SWS_ST_RD_LAST: begin
                nxt_state = `SWS_ST_DONE; // R9
            end
            `SWS_ST_WR_WAIT: begin
                nxt_state = `SWS_ST_WR_LAST; // R1
            end
            `SWS_ST_WR_LAST: begin
                nxt_state = `SWS_ST_DONE; // R9
            end
            `SWS_ST_DONE: begin
                // transceivers off here; the held strobe was already cleared while they were enabled
                nxt_state = `SWS_ST_IDLE; // R8
            end
            default: begin
                nxt_state = `SWS_ST_IDLE;
            end
        endcase
    end

    // three state bits on the rising edge
    always @(posedge clk_sys) begin // R6 R11
        if (!rstn) begin
            state_ff <= `SWS_ST_IDLE;
        end else begin
            state_ff <= nxt_state;
        end
    end

    // outputs are registered decodes of the same next state
    sws_out_decode u_decode (
        .clk_sys     (clk_sys),
        .rstn        (rstn),
        .nxtState    (nxt_state),
        .ready_ff    (ready),
        .memOeN_ff   (memoryOutputEnableN),   // R4
        .memWrN_ff   (memoryWritePulseN),     // R4
        .xcvrEnN_ff  (transceiverEnableN),    // R5
        .xcvrDirN_ff (transceiverDirectionN)  // R5
    );

    assign stateVars = state_ff; // R6

endmodule // sws_sequencer

`default_nettype wire

// ==== verification/sws_seq_asserts.sv ====
`timescale 1ns/1ps
`default_nettype none
module sws_seq_asserts (
    // clock and reset
    input wire logic       clk_sys,
    input wire logic       rstn,
    // bus inputs
    input wire logic       busCycleStatusBit,
    input wire logic       readStrobeN,
    input wire logic       writeStrobeN,
    input wire logic       heldAddressLatchN,
    input wire logic       sramSelectN,
    // watched outputs
    input wire logic       ready,
    input wire logic       memoryOutputEnableN,
    input wire logic       memoryWritePulseN,
    input wire logic       transceiverEnableN,
    input wire logic       transceiverDirectionN,
    input wire logic [2:0] stateVars
);
    default clocking @(posedge clk_sys); endclocking
    default disable iff (!rstn);
    // idle with every qualifier present
    wire logic go = stateVars == 3'h0 && !busCycleStatusBit &&
        !sramSelectN && !heldAddressLatchN;
    property p_wait; !ready |=> ready; endproperty
    a_wait: assert property (p_wait) else $error("wait too long");
    property p_rd; go && !readStrobeN |=> !ready && !memoryOutputEnableN;
    endproperty
    a_rd: assert property (p_rd) else $error("read start");
    property p_wr; go && readStrobeN && !writeStrobeN |=> !ready &&
        !memoryWritePulseN; endproperty
    a_wr: assert property (p_wr) else $error("write start");
    property p_span; $fell(transceiverEnableN) |=> !transceiverEnableN
        ##1 transceiverEnableN ##1 stateVars == 3'h0; endproperty
    a_span: assert property (p_span) else $error("access span");
    property p_dir; !transceiverEnableN |->
        transceiverDirectionN == memoryOutputEnableN; endproperty
    a_dir: assert property (p_dir) else $error("direction");
    property p_oe; !memoryOutputEnableN |-> stateVars[2:1] == 2'h1;
    endproperty
    a_oe: assert property (p_oe) else $error("oe state");
    property p_wrs; !memoryWritePulseN |-> stateVars[2:1] == 2'h2;
    endproperty
    a_wrs: assert property (p_wrs) else $error("write state");
    property p_idle; stateVars == 3'h0 && !go |=> stateVars == 3'h0 &&
        memoryOutputEnableN && memoryWritePulseN; endproperty
    a_idle: assert property (p_idle) else $error("not idle");
    c_rd: cover property (go && !readStrobeN);
    c_wr: cover property (go && readStrobeN && !writeStrobeN);
    c_ref: cover property (stateVars == 3'h0 && !heldAddressLatchN && !go);
endmodule // sws_seq_asserts
bind sws_sequencer sws_seq_asserts u_sws_seq_asserts (.clk_sys(clk_sys),
    .rstn(rstn), .busCycleStatusBit(busCycleStatusBit),
    .readStrobeN(readStrobeN), .writeStrobeN(writeStrobeN),
    .heldAddressLatchN(heldAddressLatchN), .sramSelectN(sramSelectN),
    .ready(ready), .memoryOutputEnableN(memoryOutputEnableN),
    .memoryWritePulseN(memoryWritePulseN), .stateVars(stateVars),
    .transceiverEnableN(transceiverEnableN),
    .transceiverDirectionN(transceiverDirectionN));
`default_nettype wire

// ==== verification/sws_bus_model.sv ====
`timescale 1ns/1ps
`default_nettype none
module sws_bus_model (
    // clock and address latch pulse
    input  wire logic clk_sys,
    input  wire logic addrLatchPulse,
    // transceiver enable from the sequencer
    input  wire logic transceiverEnableN,
    // held strobe back to the sequencer
    output var logic  heldAddressLatchN
);
    logic heldN_ff = 1'h1;
    // set by the pulse, cleared once transceivers open
    always @(posedge clk_sys) begin
        if (addrLatchPulse) heldN_ff <= 1'h0;
        else if (!transceiverEnableN) heldN_ff <= 1'h1;
    end
    assign heldAddressLatchN = heldN_ff;
endmodule // sws_bus_model
`default_nettype wire

// ==== verification/tb_top.sv ====
`timescale 1ns/1ps
`default_nettype none
`include "sws_seq_regs.vh"
module tb_top;
    logic clk_sys = 1'h0, rstn = 1'h0, bcs = 1'h1, rdN = 1'h1, wrN = 1'h1;
    logic selN = 1'h1, ale = 1'h0, rdy, oeN, wrPN, enN, dirN, heldN;
    logic [2:0] sv;
    int n_errors = 0, num_checks = 0;
    always #2 clk_sys = ~clk_sys;
    sws_sequencer u_sws_sequencer (.clk_sys(clk_sys), .rstn(rstn),
        .busCycleStatusBit(bcs), .readStrobeN(rdN), .writeStrobeN(wrN),
        .heldAddressLatchN(heldN), .sramSelectN(selN), .ready(rdy),
        .memoryOutputEnableN(oeN), .memoryWritePulseN(wrPN),
        .transceiverEnableN(enN), .transceiverDirectionN(dirN),
        .stateVars(sv));
    sws_bus_model u_sws_bus_model (.clk_sys(clk_sys), .addrLatchPulse(ale),
        .transceiverEnableN(enN), .heldAddressLatchN(heldN));
    // compare outputs {ready,oe,wr,en,dir,state} with the model
    task automatic chk(input logic [7:0] e);
        num_checks++;
        if ({rdy, oeN, wrPN, enN, dirN, sv} !== e) begin
            n_errors++;
            $display("CHECK FAILED %0t want %h", $time, e);
        end
    endtask
    // rule model: outputs k cycles after the taking edge
    function automatic logic [7:0] want(input int rd, input int ok,
                                        input int k);
        int act;
        logic [2:0] st;
        act = ok && k < 2;
        st = `SWS_ST_IDLE;
        if (ok && k == 0)
            st = rd ? `SWS_ST_RD_WAIT : `SWS_ST_WR_WAIT;
        if (ok && k == 1)
            st = rd ? `SWS_ST_RD_LAST : `SWS_ST_WR_LAST;
        if (ok && k == 2)
            st = `SWS_ST_DONE;
        return {!(ok && k == 0), !(act && rd), !(act && !rd), !act,
                !(act && rd), st};
    endfunction
    // latch pulse, then qualifiers, then four watched cycles
    task automatic access(logic b, logic s, logic r, logic w);
        int ok;
        logic [7:0] expQ[$];
        ok = !b && !s && !(r && w);
        for (int k = 0; k < 4; k++)
            expQ.push_back(want(!r, ok, k));
        @(posedge clk_sys) ale <= 1'h1;
        {bcs, selN, rdN, wrN} <= 4'hf;
        @(posedge clk_sys) ale <= 1'h0;
        {bcs, selN, rdN, wrN} <= {b, s, r, w};
        repeat (4) begin
            @(posedge clk_sys);
            #1 chk(expQ.pop_front());
        end
    endtask
    // print counts and verdict, then stop
    task automatic conclude;
        $display("checks %0d errors %0d", num_checks, n_errors);
        if (n_errors == 0 && num_checks > 0) $display("No errors found");
        else $display("Errors were found");
        $finish;
    endtask
    // reset, then random accesses and refusals
    initial begin
        void'($urandom(32'h3d02));
        repeat (3) @(posedge clk_sys);
        rstn <= 1'h1;
        #1 chk(want(0, 0, 0));
        for (int i = 0; i < 300; i++)
            access($urandom % 5 == 0, $urandom % 5 == 0, $urandom % 2,
                $urandom % 2);
        conclude;
    end
endmodule // tb_top
`default_nettype wire
